/* hw/wgas_fifo.sv */
/*
 sample fifo in flip-flops with valid/full on the write side and valid/ready on the read side.
 assumes one clock; the writer honours o_full.
*/
module wgas_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2048
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// write side
	input wire logic i_wr_valid,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_full,
	// read side
	input wire logic i_rd_ready,
	output logic o_rd_valid,
	output logic [WIDTH-1:0] o_rd_data,
	output logic [$clog2(DEPTH):0] o_level
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} wgas_fifo_s;
	wgas_fifo_s st_reg, st_next;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic do_wr;
	logic do_rd;
	assign o_level = st_reg.wp - st_reg.rp;
	assign o_full = (o_level == (AW+1)'(DEPTH));
	assign o_rd_valid = (st_reg.wp != st_reg.rp);
	assign do_wr = i_wr_valid && !o_full;
	assign do_rd = i_rd_ready && o_rd_valid;
	assign o_rd_data = mem_reg[st_reg.rp[AW-1:0]];
	always_comb begin
		st_next = st_reg;
		if (do_wr) begin
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (do_rd) begin
			st_next.rp = st_reg.rp + 1'b1;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (do_wr) begin
			mem_reg[st_reg.wp[AW-1:0]] <= i_wr_data;
		end
	end
endmodule : wgas_fifo

/* hw/wgas_pkg.sv */
/*
 constants, register map and state types of the wide gain acquisition sequencer.
 assumes a single 100 MHz core clock and a classic wishbone master with 32-bit data.
*/
package wgas_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int MAX_RATE_SPS = 100_000;
	localparam int MIN_CONV_CYC = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
	localparam int NUM_GAINS = 12;
	localparam int NUM_RANGES = 2 * NUM_GAINS;
	localparam int NUM_CAL_DAC = 3;
	localparam int QUEUE_DEPTH = 256;
	localparam int FIFO_DEPTH = 2048;
	localparam int SAMPLE_W = 16;
	localparam int CAL_W = 16;
	// register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_COUNT = 12'h008;
	localparam logic [11:0] ADDR_QLEN = 12'h00c;
	localparam logic [11:0] ADDR_BURST = 12'h010;
	localparam logic [11:0] ADDR_PACE = 12'h014;
	localparam logic [11:0] ADDR_POST = 12'h018;
	localparam logic [11:0] ADDR_DATA = 12'h01c;
	localparam logic [11:0] ADDR_AZERO = 12'h020;
	localparam logic [11:0] ADDR_QBASE = 12'h400;
	localparam logic [11:0] ADDR_CBASE = 12'h800;
	// control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_GO = 4;
	localparam int CTRL_ABORT = 5;
	localparam int CTRL_BURST = 6;
	localparam int CTRL_XFER_LSB = 8;
	localparam int CTRL_ANALOG = 10;
	localparam int CTRL_CLR_ERR = 11;
	// queue entry fields
	localparam int QE_CHAN_LSB = 0;
	localparam int QE_DIFF = 4;
	localparam int QE_GAIN_LSB = 5;
	localparam int QE_BIP = 9;
	typedef enum logic [2:0] {
		MODE_POST = 3'h0, MODE_PRE = 3'h1, MODE_ABOUT = 3'h2,
		MODE_START = 3'h3, MODE_STOP = 3'h4
	} wgas_mode_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_ARM = 3'b001, ST_RUN = 3'b011, ST_WAIT = 3'b010,
		ST_POST = 3'b110, ST_DONE = 3'b111
	} wgas_state_e;
endpackage : wgas_pkg

/* hw/wgas_sync.sv */
/*
 three-stage input synchroniser with second/third agreement filter.
 assumes an asynchronous level input and the core clock.
*/
module wgas_sync (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// level in and out
	input wire logic i_async,
	output logic o_level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} wgas_sync_s;
	wgas_sync_s st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.s1 = i_async;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.lvl = st_reg.s3;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign o_level = st_reg.lvl;
endmodule : wgas_sync

/* hw/wgas_top.sv */
/*
 acquisition sequencer: channel-gain queue, calibration reload, trigger modes,
 sample fifo and wishbone register slave.
 assumes a converter that takes o_conv_start and answers with i_adc_done and
 16-bit data, and three calibration converters loaded by a write strobe.
*/
// Implementation choices: register access over Wishbone and the register addresses.
module wgas_top #(
	parameter int QDEPTH = wgas_pkg::QUEUE_DEPTH,
	parameter int FDEPTH = wgas_pkg::FIFO_DEPTH,
	parameter int PRE_KEEP = 1024
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [11:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// trigger pins
	input wire logic i_ext_trig,
	input wire logic i_analog_trig,
	// converter
	output logic o_conv_start,
	output logic [3:0] o_mux_chan,
	output logic o_mux_diff,
	output logic [3:0] o_gain_sel,
	output logic o_bipolar,
	input wire logic i_adc_done,
	input wire logic [15:0] i_adc_data,
	// calibration converters
	output logic o_cal_wr,
	output logic [1:0] o_cal_idx,
	output logic [15:0] o_cal_data,
	// dma request
	output logic o_dma_req,
	output logic o_data_ready
);
	localparam int QAW = $clog2(QDEPTH);
	localparam int FLW = $clog2(FDEPTH) + 1;
	if (QDEPTH < 2 || QDEPTH > wgas_pkg::QUEUE_DEPTH) begin : g_bad_qdepth
		$error("queue depth out of range");
	end
	if (PRE_KEEP < 1 || PRE_KEEP >= FDEPTH) begin : g_bad_keep
		$error("pre-trigger keep must fit the fifo");
	end
	typedef struct packed {
		wgas_pkg::wgas_state_e state;
		logic [2:0] mode;
		logic burst;
		logic analog;
		logic [1:0] xfer;
		logic [QAW-1:0] qlen;
		logic [QAW-1:0] qidx;
		logic [31:0] count;
		logic [31:0] done_cnt;
		logic [31:0] post_cnt;
		logic [31:0] burst_ivl;
		logic [31:0] pace;
		logic [31:0] timer;
		logic [4:0] cur_range;
		logic range_valid;
		logic [1:0] cal_step;
		logic cal_busy;
		logic conv_busy;
		logic trig_d;
		logic overflow;
		logic azero;
		logic ack;
		logic [31:0] rdat;
		logic cal_wr;
		logic [1:0] cal_idx;
		logic [15:0] cal_data;
	} wgas_top_s;
	wgas_top_s st_reg, st_next;
	logic [9:0] queue_reg [QDEPTH];
	logic [15:0] cal_reg [wgas_pkg::NUM_RANGES*wgas_pkg::NUM_CAL_DAC];
	logic [15:0] az_reg [wgas_pkg::NUM_RANGES*2];
	logic ext_lvl;
	logic ana_lvl;
	logic trig_lvl;
	logic trig_edge;
	logic f_full;
	logic f_valid;
	logic [15:0] f_data;
	logic [FLW-1:0] f_level;
	logic f_wr;
	logic f_rd;
	logic [9:0] entry;
	logic [4:0] entry_range;
	logic [6:0] cal_addr;
	logic [5:0] az_addr;
	logic wb_req;
	logic wb_wr;
	logic q_hit;
	logic c_hit;
	logic [6:0] c_word;
	wgas_sync u_sync_ext (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(i_ext_trig),
		.o_level(ext_lvl)
	);
	wgas_sync u_sync_ana (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(i_analog_trig),
		.o_level(ana_lvl)
	);
	wgas_fifo #(.WIDTH(wgas_pkg::SAMPLE_W), .DEPTH(FDEPTH)) u_fifo (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_wr_valid(f_wr),
		.i_wr_data(i_adc_data),
		.o_full(f_full),
		.i_rd_ready(f_rd),
		.o_rd_valid(f_valid),
		.o_rd_data(f_data),
		.o_level(f_level)
	);
	// analog threshold only counts in about mode
	assign trig_lvl = (st_reg.analog && st_reg.mode == wgas_pkg::MODE_ABOUT) ? ana_lvl : ext_lvl;
	assign trig_edge = trig_lvl && !st_reg.trig_d;
	assign entry = queue_reg[st_reg.qidx];
	// unipolar ranges take the low slots, bipolar ranges the next twelve
	assign entry_range = entry[wgas_pkg::QE_BIP]
		? 5'(entry[wgas_pkg::QE_GAIN_LSB +: 4]) + 5'(wgas_pkg::NUM_GAINS)
		: 5'(entry[wgas_pkg::QE_GAIN_LSB +: 4]);
	assign cal_addr = 7'(entry_range) * 7'(wgas_pkg::NUM_CAL_DAC) + 7'(st_reg.cal_step);
	assign az_addr = 6'(entry_range) * 6'd2 + 6'(st_reg.cal_step);
	assign wb_req = i_wb_cyc && i_wb_stb && !st_reg.ack;
	assign wb_wr = wb_req && i_wb_we;
	assign q_hit = (i_wb_adr[11:10] == wgas_pkg::ADDR_QBASE[11:10]);
	assign c_hit = (i_wb_adr[11:10] == wgas_pkg::ADDR_CBASE[11:10]);
	assign c_word = i_wb_adr[8:2];
	// sample leaves the fifo only when software reads the data word
	assign f_rd = wb_req && !i_wb_we && !q_hit && !c_hit && i_wb_adr == wgas_pkg::ADDR_DATA;
	assign f_wr = i_adc_done && !f_full && (st_reg.state == wgas_pkg::ST_RUN || st_reg.state == wgas_pkg::ST_WAIT || st_reg.state == wgas_pkg::ST_POST);
	always_comb begin
		st_next = st_reg;
		st_next.ack = wb_req;
		st_next.trig_d = trig_lvl;
		st_next.cal_wr = 1'b0;
		if (st_reg.timer != 32'h0) begin
			st_next.timer = st_reg.timer - 32'h1;
		end
		// register reads
		st_next.rdat = 32'h0;
		case (i_wb_adr)
			wgas_pkg::ADDR_CTRL: st_next.rdat = {21'h0, st_reg.analog, st_reg.xfer, 1'b0,
				st_reg.burst, 3'h0, st_reg.mode};
			wgas_pkg::ADDR_STATUS: st_next.rdat = {(16-FLW)'(0), f_level, 10'h0, st_reg.azero, st_reg.overflow, 1'b0, st_reg.state};
			wgas_pkg::ADDR_COUNT: st_next.rdat = st_reg.count;
			wgas_pkg::ADDR_QLEN: st_next.rdat = 32'(st_reg.qlen);
			wgas_pkg::ADDR_BURST: st_next.rdat = st_reg.burst_ivl;
			wgas_pkg::ADDR_PACE: st_next.rdat = st_reg.pace;
			wgas_pkg::ADDR_POST: st_next.rdat = st_reg.post_cnt;
			wgas_pkg::ADDR_DATA: st_next.rdat = {16'h0, f_valid ? f_data : 16'h0};
			default: begin
				if (q_hit) begin
					st_next.rdat = {22'h0, queue_reg[i_wb_adr[QAW+1:2]]};
				end else if (c_hit) begin
					st_next.rdat = {16'h0, cal_reg[c_word]};
				end
			end
		endcase
		// register writes
		if (wb_wr && i_wb_sel[0]) begin
			case (i_wb_adr)
				wgas_pkg::ADDR_CTRL: begin
					st_next.mode = i_wb_dat[wgas_pkg::CTRL_MODE_LSB +: 3];
					st_next.burst = i_wb_dat[wgas_pkg::CTRL_BURST];
					st_next.xfer = i_wb_dat[wgas_pkg::CTRL_XFER_LSB +: 2];
					st_next.analog = i_wb_dat[wgas_pkg::CTRL_ANALOG];
					if (i_wb_dat[wgas_pkg::CTRL_CLR_ERR]) begin
						st_next.overflow = 1'b0;
					end
					if (i_wb_dat[wgas_pkg::CTRL_GO] && st_reg.state == wgas_pkg::ST_IDLE) begin
						st_next.state = wgas_pkg::ST_ARM;
						st_next.qidx = '0;
						st_next.done_cnt = 32'h0;
						st_next.range_valid = 1'b0;
						// a stop can cut a conversion or a reload short; start clean
						st_next.conv_busy = 1'b0;
						st_next.cal_step = 2'd0;
					end
					if (i_wb_dat[wgas_pkg::CTRL_ABORT]) begin
						st_next.state = wgas_pkg::ST_IDLE;
					end
				end
				wgas_pkg::ADDR_COUNT: st_next.count = i_wb_dat;
				wgas_pkg::ADDR_QLEN: st_next.qlen = i_wb_dat[QAW-1:0];
				wgas_pkg::ADDR_BURST: st_next.burst_ivl = i_wb_dat;
				wgas_pkg::ADDR_PACE: st_next.pace = i_wb_dat;
				wgas_pkg::ADDR_POST: st_next.post_cnt = i_wb_dat;
				wgas_pkg::ADDR_AZERO: st_next.azero = i_wb_dat[0];
				default: ;
			endcase
		end
		// sequencer
		case (st_reg.state)
			wgas_pkg::ST_IDLE: ;
			wgas_pkg::ST_ARM: begin
				// pre, about and stop acquire at once; post and start wait for the start event
				if (st_reg.mode == wgas_pkg::MODE_PRE || st_reg.mode == wgas_pkg::MODE_ABOUT || st_reg.mode == wgas_pkg::MODE_STOP || trig_edge) begin
					st_next.state = wgas_pkg::ST_RUN;
				end
			end
			wgas_pkg::ST_RUN, wgas_pkg::ST_WAIT, wgas_pkg::ST_POST: begin
				// reload three converters before converting a new range
				if (!st_reg.range_valid || entry_range != st_reg.cur_range) begin
					if (!st_reg.conv_busy) begin
						st_next.cal_busy = 1'b1;
						st_next.cal_wr = 1'b1;
						st_next.cal_idx = st_reg.cal_step;
						st_next.cal_data = (st_reg.azero && st_reg.cal_step != 2'd2)
							? az_reg[az_addr] : cal_reg[cal_addr];
						if (st_reg.cal_step == 2'd2) begin
							st_next.cal_step = 2'd0;
							st_next.cur_range = entry_range;
							st_next.range_valid = 1'b1;
							st_next.cal_busy = 1'b0;
						end else begin
							st_next.cal_step = st_reg.cal_step + 2'd1;
						end
					end
				end else if (!st_reg.conv_busy && st_reg.timer == 32'h0) begin
					st_next.conv_busy = 1'b1;
					st_next.timer = (st_reg.pace < 32'(wgas_pkg::MIN_CONV_CYC)) ? 32'(wgas_pkg::MIN_CONV_CYC) : st_reg.pace;
				end
				if (st_reg.conv_busy && i_adc_done) begin
					st_next.conv_busy = 1'b0;
					st_next.done_cnt = st_reg.done_cnt + 32'h1;
					if (st_reg.qidx == st_reg.qlen) begin
						st_next.qidx = '0;
						if (st_reg.burst) begin
							// a short interval must not undercut the running rate floor
							if (st_reg.burst_ivl > st_reg.timer) begin
								st_next.timer = st_reg.burst_ivl;
							end
						end
					end else begin
						st_next.qidx = st_reg.qidx + 1'b1;
					end
					if (st_reg.state == wgas_pkg::ST_POST && st_reg.done_cnt + 32'h1 >= st_reg.post_cnt) begin
						st_next.state = wgas_pkg::ST_DONE;
					end
					if (st_reg.mode == wgas_pkg::MODE_POST && st_reg.count != 32'h0 && st_reg.done_cnt + 32'h1 >= st_reg.count) begin
						st_next.state = wgas_pkg::ST_DONE;
					end
				end
				if (trig_edge && st_reg.state != wgas_pkg::ST_POST) begin
					case (st_reg.mode)
						wgas_pkg::MODE_PRE, wgas_pkg::MODE_STOP, wgas_pkg::MODE_POST: st_next.state = wgas_pkg::ST_DONE;
						wgas_pkg::MODE_ABOUT: begin
							st_next.state = wgas_pkg::ST_POST;
							st_next.done_cnt = 32'h0;
						end
						default: ;
					endcase
				end
			end
			wgas_pkg::ST_DONE: st_next.state = wgas_pkg::ST_IDLE;
			default: st_next.state = wgas_pkg::ST_IDLE;
		endcase
		if (i_adc_done && f_full && st_reg.conv_busy) begin
			st_next.overflow = 1'b1;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			st_reg <= '0;
			st_reg.state <= wgas_pkg::ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end
	// table writes from the bus; tables carry no reset
	always_ff @(posedge i_core_clk) begin
		if (wb_wr && q_hit) begin
			queue_reg[i_wb_adr[QAW+1:2]] <= i_wb_dat[9:0];
		end
		if (wb_wr && c_hit && c_word < 7'(wgas_pkg::NUM_RANGES*3)) begin
			cal_reg[c_word] <= i_wb_dat[15:0];
		end
		if (wb_wr && c_hit && c_word >= 7'(wgas_pkg::NUM_RANGES*3) && c_word < 7'(wgas_pkg::NUM_RANGES*5)) begin
			az_reg[6'(c_word - 7'(wgas_pkg::NUM_RANGES*3))] <= i_wb_dat[15:0];
		end
	end
	assign o_wb_ack = st_reg.ack;
	assign o_wb_dat = st_reg.rdat;
	assign o_conv_start = st_next.conv_busy && !st_reg.conv_busy;
	assign o_mux_chan = entry[wgas_pkg::QE_CHAN_LSB +: 4];
	assign o_mux_diff = entry[wgas_pkg::QE_DIFF];
	assign o_gain_sel = entry[wgas_pkg::QE_GAIN_LSB +: 4];
	assign o_bipolar = entry[wgas_pkg::QE_BIP];
	assign o_cal_wr = st_reg.cal_wr;
	assign o_cal_idx = st_reg.cal_idx;
	assign o_cal_data = st_reg.cal_data;
	assign o_dma_req = f_valid && st_reg.xfer == 2'd0;
	assign o_data_ready = f_valid;
endmodule : wgas_top

/* testbench/wgas_adc_model.sv */
/*
 behavioural converter facing the sequencer.
 assumes a one-cycle start pulse and answers with a one-cycle done pulse.
*/
module wgas_adc_model (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// request and selection
	input wire logic i_conv_start,
	input wire logic [3:0] i_chan,
	input wire logic i_diff,
	input wire logic [3:0] i_gain,
	input wire logic i_bip,
	input wire logic i_slow,
	// result
	output logic o_done,
	output logic [15:0] o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] seq_reg;
	logic [15:0] word_reg;
	int wait_reg;
	// data toggles outside the done pulse so a late sample never looks valid
	always_ff @(posedge i_core_clk) begin
		o_done <= 1'b0;
		o_data <= ~o_data;
		if (i_srst) begin
			seq_reg <= 6'h0;
			wait_reg <= 0;
			o_data <= 16'h0;
		end else if (i_conv_start) begin
			word_reg <= {seq_reg, i_bip, i_gain, i_diff, i_chan};
			seq_reg <= seq_reg + 6'h1;
			wait_reg <= i_slow ? 400 : 40;
		end else if (wait_reg == 1) begin
			o_done <= 1'b1;
			o_data <= word_reg;
			wait_reg <= 0;
		end else if (wait_reg > 1) begin
			wait_reg <= wait_reg - 1;
		end
	end
endmodule : wgas_adc_model

/* testbench/wgas_monitor.sv */
/*
 port checker for the acquisition sequencer: bus answer, calibration reload,
 conversion spacing and transfer flags.
 assumes it is bound onto wgas_top and that everything runs on the core clock.
*/
module wgas_monitor (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// bus
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic o_wb_ack,
	// converter
	input wire logic o_conv_start,
	input wire logic [3:0] o_mux_chan,
	input wire logic o_mux_diff,
	input wire logic [3:0] o_gain_sel,
	input wire logic o_bipolar,
	input wire logic o_cal_wr,
	input wire logic [1:0] o_cal_idx,
	// transfer
	input wire logic o_dma_req,
	input wire logic o_data_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);
	logic [10:0] gap_reg;
	logic seen_reg;
	// saturates so that a long idle never wraps into a false short gap
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			gap_reg <= 11'h0;
			seen_reg <= 1'b0;
		end else if (o_conv_start) begin
			gap_reg <= 11'h1;
			seen_reg <= 1'b1;
		end else if (gap_reg != 11'h7ff) begin
			gap_reg <= gap_reg + 11'h1;
		end
	end
	sequence cal_load_s;
		o_cal_wr && o_cal_idx == 2'h0 ##1 o_cal_wr && o_cal_idx == 2'h1
			##1 o_cal_wr && o_cal_idx == 2'h2;
	endsequence
	sequence cal_end_s;
		o_cal_wr && o_cal_idx == 2'h2;
	endsequence
	chk_reset_quiet: assert property ($fell(i_srst) |-> !o_wb_ack && !o_conv_start
		&& !o_cal_wr && !o_data_ready) else $error("outputs active after reset");
	chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus request not answered in one cycle");
	chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	chk_cal_first: assert property ($rose(o_cal_wr) |-> o_cal_idx == 2'h0)
		else $error("calibration load not starting at first converter");
	chk_cal_order: assert property (o_cal_wr && o_cal_idx == 2'h0 |-> cal_load_s ##1 !o_cal_wr)
		else $error("calibration load not three ordered writes");
	chk_cal_conv: assert property (cal_end_s |-> ##[0:1000] o_conv_start)
		else $error("conversion late after calibration load");
	chk_conv_space: assert property (o_conv_start && seen_reg |-> gap_reg >= 11'h3e8)
		else $error("conversions closer than the rate limit");
	chk_mux_hold: assert property (o_conv_start |=>
		$stable({o_mux_chan, o_mux_diff, o_gain_sel, o_bipolar}) [*8])
		else $error("selection changed during conversion");
	chk_dma_ready: assert property (o_dma_req |-> o_data_ready)
		else $error("dma request with empty buffer");
endmodule : wgas_monitor

bind wgas_top wgas_monitor chk_u (.*);

/* testbench/wgas_top_test.sv */
/*
 self-checking bench for the acquisition sequencer over wishbone.
 assumes the converter model and the bound port checker.
*/
module wgas_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FD = 8;
	localparam logic [31:0] GO = 32'h1 << wgas_pkg::CTRL_GO;
	localparam logic [31:0] ABORT = 32'h1 << wgas_pkg::CTRL_ABORT;
	logic i_core_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_wb_cyc = 1'b0;
	logic i_wb_stb = 1'b0;
	logic i_wb_we = 1'b0;
	logic [11:0] i_wb_adr = 12'h0;
	logic [3:0] i_wb_sel = 4'hf;
	logic [31:0] i_wb_dat = 32'h0;
	logic i_ext_trig = 1'b0;
	logic i_analog_trig = 1'b0;
	logic slow = 1'b0;
	logic i_adc_done, o_wb_ack, o_conv_start, o_mux_diff, o_bipolar, o_cal_wr;
	logic o_dma_req, o_data_ready;
	logic [15:0] i_adc_data, o_cal_data;
	logic [31:0] o_wb_dat, rdat;
	logic [3:0] o_mux_chan, o_gain_sel;
	logic [1:0] o_cal_idx;
	logic [15:0] expq[$];
	logic [15:0] calq[$];
	logic [9:0] ent [3] = '{10'h003, 10'h375, 10'h377};
	logic [2:0] modes [3] = '{wgas_pkg::MODE_PRE, wgas_pkg::MODE_STOP, wgas_pkg::MODE_ABOUT};
	int post_n [3] = '{0, 0, 3};
	int failures = 0;
	int n_checks = 0;
	int n_conv = 0;
	int n1, j, r;

	always #5 i_core_clk = ~i_core_clk;
	wgas_top #(.FDEPTH(FD), .PRE_KEEP(FD / 2)) dut_u (.*);
	wgas_adc_model adc_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_conv_start(o_conv_start),
		.i_chan(o_mux_chan), .i_diff(o_mux_diff), .i_gain(o_gain_sel), .i_bip(o_bipolar),
		.i_slow(slow), .o_done(i_adc_done), .o_data(i_adc_data));

	always @(posedge i_core_clk) begin
		if (!i_srst && o_conv_start) begin
			expq.push_back({n_conv[5:0], o_bipolar, o_gain_sel, o_mux_diff, o_mux_chan});
			n_conv++;
		end
		if (!i_srst && o_cal_wr) calq.push_back(o_cal_data);
	end

	function automatic int rng(logic [9:0] e);
		return int'(e[8:5]) + (e[9] ? wgas_pkg::NUM_GAINS : 0);
	endfunction : rng
	function automatic logic [15:0] calv(int rr, int s, bit az);
		return 16'ha000 | (16'(rr * 4 + s) ^ (az ? 16'h0f00 : 16'h0));
	endfunction : calv
	task automatic final_report();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		do begin
			@(posedge i_core_clk);
		end while (o_wb_ack !== 1'b1);
		rdat = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we <= 1'b0;
		@(posedge i_core_clk);
	endtask : wb
	task automatic wait_conv(input int n);
		while (n_conv < n) begin
			@(posedge i_core_clk);
		end
	endtask : wait_conv
	// samples beyond the buffer depth are expected to be dropped, oldest kept
	task automatic drain();
		int lvl;
		wb(1'b0, wgas_pkg::ADDR_STATUS, 32'h0);
		lvl = int'(rdat[31:16]);
		chk(lvl, expq.size() > FD ? FD : expq.size());
		repeat (lvl) begin
			wb(1'b0, wgas_pkg::ADDR_DATA, 32'h0);
			chk(rdat, {16'h0, expq.pop_front()});
		end
		expq.delete();
	endtask : drain

	initial begin
		repeat (95000) @(posedge i_core_clk);
		failures++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge i_core_clk);
		i_srst <= 1'b0;
		@(posedge i_core_clk);
		wb(1'b1, 12'h0f0, 32'h5a);
		wb(1'b0, 12'h0f0, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, wgas_pkg::ADDR_COUNT, 32'h6);
		wb(1'b1, wgas_pkg::ADDR_QLEN, 32'h2);
		wb(1'b0, wgas_pkg::ADDR_QLEN, 32'h0);
		chk(rdat, 32'h2);
		wb(1'b1, wgas_pkg::ADDR_POST, 32'h3);
		wb(1'b1, wgas_pkg::ADDR_AZERO, 32'h1);
		foreach (ent[i]) wb(1'b1, wgas_pkg::ADDR_QBASE + 12'(4 * i), 32'(ent[i]));
		for (int i = 0; i < 2; i++) begin
			r = rng(ent[i]);
			for (int s = 0; s < 3; s++) begin
				wb(1'b1, wgas_pkg::ADDR_CBASE + 12'(4 * (r * 3 + s)), 32'(calv(r, s, 1'b0)));
				if (s < 2) wb(1'b1, wgas_pkg::ADDR_CBASE + 12'(4 * (72 + r * 2 + s)),
					32'(calv(r, s, 1'b1)));
			end
		end
		wb(1'b1, wgas_pkg::ADDR_CTRL, 32'(wgas_pkg::MODE_POST) | GO | 32'h200);
		wb(1'b0, wgas_pkg::ADDR_CTRL, 32'h0);
		chk(rdat, 32'h200);
		repeat (50) @(posedge i_core_clk);
		chk(n_conv, 0);
		i_ext_trig <= 1'b1;
		wait_conv(6);
		repeat (3000) @(posedge i_core_clk);
		chk(n_conv, 6);
		chk({o_dma_req, o_data_ready}, 2'b01);
		for (int k = 0; k < 6; k++) chk(expq[k][9:0], ent[k % 3]);
		j = 0;
		for (int k = 0; k < 6; k++) begin
			if (k % 3 != 2) begin
				for (int s = 0; s < 3; s++) begin
					chk(calq[j], calv(rng(ent[k % 3]), s, s < 2));
					j++;
				end
			end
		end
		chk(calq.size(), 12);
		drain();
		chk(o_data_ready, 1'b0);
		i_ext_trig <= 1'b0;
		wb(1'b1, wgas_pkg::ADDR_CTRL, ABORT);
		slow <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			wb(1'b1, wgas_pkg::ADDR_CTRL, 32'(modes[m]) | GO | (m == 2 ? 32'h400 : 32'h0));
			wait_conv(n_conv + 2);
			repeat (500) @(posedge i_core_clk);
			if (m == 2) i_analog_trig <= 1'b1;
			else i_ext_trig <= 1'b1;
			n1 = n_conv;
			repeat (3000) @(posedge i_core_clk);
			chk(n_conv - n1, post_n[m]);
			i_analog_trig <= 1'b0;
			i_ext_trig <= 1'b0;
			drain();
			wb(1'b1, wgas_pkg::ADDR_CTRL, ABORT);
		end
		wb(1'b1, wgas_pkg::ADDR_CTRL, 32'(wgas_pkg::MODE_START) | GO);
		n1 = n_conv;
		repeat (300) @(posedge i_core_clk);
		chk(n_conv - n1, 0);
		i_ext_trig <= 1'b1;
		wait_conv(n1 + 2);
		repeat (500) @(posedge i_core_clk);
		wb(1'b1, wgas_pkg::ADDR_CTRL, ABORT);
		i_ext_trig <= 1'b0;
		chk(n_conv - n1, 2);
		drain();
		wb(1'b1, wgas_pkg::ADDR_CTRL, 32'(wgas_pkg::MODE_PRE) | GO);
		wait_conv(n_conv + FD + 2);
		// stop before the reload for the next range, so no reload is cut short
		repeat (300) @(posedge i_core_clk);
		i_ext_trig <= 1'b1;
		repeat (100) @(posedge i_core_clk);
		wb(1'b0, wgas_pkg::ADDR_STATUS, 32'h0);
		chk(rdat[4], 1'b1);
		drain();
		wb(1'b1, wgas_pkg::ADDR_CTRL, ABORT | (32'h1 << wgas_pkg::CTRL_CLR_ERR));
		wb(1'b0, wgas_pkg::ADDR_STATUS, 32'h0);
		chk(rdat[4], 1'b0);
		final_report();
	end
endmodule : wgas_top_test
